//--- afc_defines.svh
/*
 * Constants of the FIFO pin controller: timing, register map, fields.
 * Assumes a 10 ns system clock and the fastest speed grade of the device.
 */
`ifndef AFC_DEFINES_SVH
`define AFC_DEFINES_SVH

`define AFC_CLK_NS 10
`define AFC_PULSE_NS 25
`define AFC_RECOV_NS 8
`define AFC_FLAG_NS 33
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_CYC ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_FLAG_CYC ((`AFC_FLAG_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_CNT_W 3

`define AFC_WORD_W 9
`define AFC_BUF_DEPTH 8

`define AFC_REG_CTRL 8'h00
`define AFC_REG_STATUS 8'h04
`define AFC_REG_TXDATA 8'h08
`define AFC_REG_RXDATA 8'h0C

`define AFC_CTRL_CHAIN 0
`define AFC_CTRL_HEAD 1
`define AFC_CTRL_AUTO 2
`define AFC_CTRL_RESET 4
`define AFC_CTRL_REPLAY 5

`define AFC_ST_EMPTY_N 0
`define AFC_ST_FULL_N 1
`define AFC_ST_HALF_N 2
`define AFC_ST_BUSY 3
`define AFC_ST_RXVALID 4
`define AFC_ST_DROP 5
`define AFC_ST_TXPEND 6

`define AFC_RX_VALID 16

`endif

//--- afc_pkg.sv
/*
 * Types of the FIFO pin controller.
 * Assumes afc_defines.svh for the numbers.
 */
package afc_pkg;

    typedef enum logic [8:0] {
        AFC_IDLE = 9'h001,
        AFC_RST_LO = 9'h002,
        AFC_RST_REC = 9'h004,
        AFC_WR_LO = 9'h008,
        AFC_WR_HI = 9'h010,
        AFC_RD_LO = 9'h020,
        AFC_RD_HI = 9'h040,
        AFC_RT_LO = 9'h080,
        AFC_RT_REC = 9'h100
    } afc_state_t;

endpackage : afc_pkg

//--- afc_buf.sv
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none

module afc_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("afc_buf: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_q, wr_ptr_d;
    logic [AW:0] rd_ptr_q, rd_ptr_d;
    logic push, pop;

    assign in_ready = (wr_ptr_q - rd_ptr_q) != (AW + 1)'(DEPTH);
    assign out_valid = wr_ptr_q != rd_ptr_q;
    assign out_data = mem[rd_ptr_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        if (push) begin
            wr_ptr_d = wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
        end
    end

    // Storage needs no reset; words are only read once written
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

endmodule : afc_buf

`default_nettype wire

//--- afc_ctrl.sv
/*
 * Controller that drives a strobe-timed nine-bit FIFO device through its
 * pins, with a small register port for software and a receive buffer.
 * Assumes one device on its pins, device inputs synchronous to clk, and
 * a software master that keeps the plain strobe protocol.
 */
// Contract
// - A standalone device has its token input held low.
// - Paralleled devices share controls; flags come from any one.
// - Never join status or chain outputs of two devices.
// - Every chain member except the head has its select held high.
// - Each token output feeds the next device's token input.
// - Outside logic combines chained full and empty flags.
// - Watch full where writing and empty where reading.
`timescale 1ns/100ps
`default_nettype none

`include "afc_defines.svh"

module afc_ctrl
    import afc_pkg::*;
#(
    parameter int WORD_W = `AFC_WORD_W,
    parameter int BUF_DEPTH = `AFC_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic reset_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic head_or_replay_input_n,
    output logic chain_token_in_n,
    output logic chain_token_in_oe_n,
    output logic [WORD_W-1:0] write_data,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic empty_indicator_n,
    input wire logic full_indicator_n,
    input wire logic half_level_indicator_n
);
    localparam logic [`AFC_CNT_W-1:0] PULSE_LAST =
        `AFC_CNT_W'(`AFC_PULSE_CYC - 1);
    localparam logic [`AFC_CNT_W-1:0] SETTLE_LAST =
        `AFC_CNT_W'(`AFC_FLAG_CYC - 1);
    localparam logic [`AFC_CNT_W-1:0] RECOV_LAST =
        `AFC_CNT_W'(`AFC_RECOV_CYC - 1);

    generate
        if (WORD_W != `AFC_WORD_W) begin : g_bad_width
            $error("afc_ctrl: the device word is nine bits wide");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Register port

    logic chain_q, chain_d;
    logic head_q, head_d;
    logic auto_q, auto_d;
    logic rst_pend_q, rst_pend_d;
    logic rt_pend_q, rt_pend_d;
    logic tx_pend_q, tx_pend_d;
    logic [WORD_W-1:0] tx_word_q, tx_word_d;
    logic drop_q, drop_d;
    logic [2:0] flags_q, flags_d;
    logic [31:0] rdata_q, rdata_d;

    logic wr_ctrl, wr_stat, wr_tx, rd_rx;
    logic tx_take, rst_take, rt_take, busy;
    logic buf_in_valid, buf_in_ready, buf_out_valid;
    logic [WORD_W-1:0] buf_out_data;
    afc_state_t state_q, state_d;

    assign wr_ctrl = reg_wr && reg_addr == `AFC_REG_CTRL;
    assign wr_stat = reg_wr && reg_addr == `AFC_REG_STATUS;
    assign wr_tx = reg_wr && reg_addr == `AFC_REG_TXDATA;
    assign rd_rx = reg_rd && reg_addr == `AFC_REG_RXDATA;
    assign busy = state_q != AFC_IDLE;

    always_comb begin
        chain_d = chain_q;
        head_d = head_q;
        auto_d = auto_q;
        rst_pend_d = rst_pend_q && !rst_take;
        rt_pend_d = rt_pend_q && !rt_take;
        tx_pend_d = tx_pend_q && !tx_take;
        tx_word_d = tx_word_q;
        drop_d = drop_q;
        // Flags taken from this one device only
        flags_d = {half_level_indicator_n, full_indicator_n,
                   empty_indicator_n};
        if (wr_ctrl) begin
            chain_d = reg_wdata[`AFC_CTRL_CHAIN];
            head_d = reg_wdata[`AFC_CTRL_HEAD];
            auto_d = reg_wdata[`AFC_CTRL_AUTO];
            if (reg_wdata[`AFC_CTRL_RESET]) begin
                rst_pend_d = 1'b1;
            end
            if (reg_wdata[`AFC_CTRL_REPLAY]) begin
                rt_pend_d = 1'b1;
            end
        end
        // Clear first so that a drop in the same cycle still sets
        if (wr_stat && reg_wdata[`AFC_ST_DROP]) begin
            drop_d = 1'b0;
        end
        if (wr_tx) begin
            if (!tx_pend_q || tx_take) begin
                tx_pend_d = 1'b1;
                tx_word_d = reg_wdata[WORD_W-1:0];
            end else begin
                drop_d = 1'b1;
            end
        end
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `AFC_REG_CTRL: begin
                    rdata_d[`AFC_CTRL_CHAIN] = chain_q;
                    rdata_d[`AFC_CTRL_HEAD] = head_q;
                    rdata_d[`AFC_CTRL_AUTO] = auto_q;
                    rdata_d[`AFC_CTRL_RESET] = rst_pend_q;
                    rdata_d[`AFC_CTRL_REPLAY] = rt_pend_q;
                end
                `AFC_REG_STATUS: begin
                    rdata_d[`AFC_ST_HALF_N:`AFC_ST_EMPTY_N] = flags_q;
                    rdata_d[`AFC_ST_BUSY] = busy;
                    rdata_d[`AFC_ST_RXVALID] = buf_out_valid;
                    rdata_d[`AFC_ST_DROP] = drop_q;
                    rdata_d[`AFC_ST_TXPEND] = tx_pend_q;
                end
                `AFC_REG_RXDATA: begin
                    rdata_d[WORD_W-1:0] = buf_out_data;
                    rdata_d[`AFC_RX_VALID] = buf_out_valid;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chain_q <= 1'b0;
            head_q <= 1'b0;
            auto_q <= 1'b0;
            rst_pend_q <= 1'b0;
            rt_pend_q <= 1'b0;
            tx_pend_q <= 1'b0;
            tx_word_q <= '0;
            drop_q <= 1'b0;
            flags_q <= 3'h6;
            rdata_q <= '0;
        end else begin
            chain_q <= chain_d;
            head_q <= head_d;
            auto_q <= auto_d;
            rst_pend_q <= rst_pend_d;
            rt_pend_q <= rt_pend_d;
            tx_pend_q <= tx_pend_d;
            tx_word_q <= tx_word_d;
            drop_q <= drop_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin sequencer

    logic [`AFC_CNT_W-1:0] cnt_q, cnt_d;
    logic rs_n_q, rs_n_d;
    logic wr_n_q, wr_n_d;
    logic rd_n_q, rd_n_d;
    logic hr_n_q, hr_n_d;
    logic tok_oe_n_q, tok_oe_n_d;
    logic [WORD_W-1:0] wdat_q, wdat_d;
    logic cnt_done;

    assign cnt_done = cnt_q == '0;
    assign rst_take = state_q == AFC_IDLE && rst_pend_q;
    assign rt_take = state_q == AFC_IDLE && !rst_pend_q && rt_pend_q;
    assign tx_take = state_q == AFC_IDLE && !rst_pend_q && !rt_pend_q
                     && tx_pend_q && full_indicator_n;
    // Word is pushed at the end of the low phase, after the access time
    assign buf_in_valid = state_q == AFC_RD_LO && cnt_done;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        rs_n_d = rs_n_q;
        wr_n_d = wr_n_q;
        rd_n_d = rd_n_q;
        wdat_d = wdat_q;
        // Head of a chain selects low, other members high, alone idle high
        hr_n_d = chain_q ? !head_q : 1'b1;
        // Released in a chain so the previous device drives the token
        tok_oe_n_d = chain_q;
        unique case (state_q)
            AFC_IDLE: begin
                if (rst_take) begin
                    state_d = AFC_RST_LO;
                    rs_n_d = 1'b0;
                    cnt_d = PULSE_LAST;
                end else if (rt_take) begin
                    // Replay is not offered once devices are chained
                    if (!chain_q) begin
                        state_d = AFC_RT_LO;
                        hr_n_d = 1'b0;
                        cnt_d = PULSE_LAST;
                    end
                end else if (tx_take) begin
                    state_d = AFC_WR_LO;
                    wr_n_d = 1'b0;
                    wdat_d = tx_word_q;
                    cnt_d = PULSE_LAST;
                end else if (auto_q && empty_indicator_n
                             && buf_in_ready) begin
                    state_d = AFC_RD_LO;
                    rd_n_d = 1'b0;
                    cnt_d = PULSE_LAST;
                end
            end
            AFC_RST_LO: begin
                if (cnt_done) begin
                    state_d = AFC_RST_REC;
                    rs_n_d = 1'b1;
                    cnt_d = SETTLE_LAST;
                end
            end
            AFC_WR_LO: begin
                if (cnt_done) begin
                    state_d = AFC_WR_HI;
                    wr_n_d = 1'b1;
                    cnt_d = SETTLE_LAST;
                end
            end
            AFC_RD_LO: begin
                if (cnt_done) begin
                    state_d = AFC_RD_HI;
                    rd_n_d = 1'b1;
                    cnt_d = SETTLE_LAST;
                end
            end
            AFC_RT_LO: begin
                hr_n_d = 1'b0;
                if (cnt_done) begin
                    state_d = AFC_RT_REC;
                    cnt_d = RECOV_LAST;
                end
            end
            AFC_RST_REC, AFC_WR_HI, AFC_RD_HI, AFC_RT_REC: begin
                if (cnt_done) begin
                    state_d = AFC_IDLE;
                end
            end
            default: begin
                state_d = AFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= AFC_IDLE;
            cnt_q <= '0;
            rs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            hr_n_q <= 1'b1;
            tok_oe_n_q <= 1'b0;
            wdat_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rs_n_q <= rs_n_d;
            wr_n_q <= wr_n_d;
            rd_n_q <= rd_n_d;
            hr_n_q <= hr_n_d;
            tok_oe_n_q <= tok_oe_n_d;
            wdat_q <= wdat_d;
        end
    end

    assign reset_n = rs_n_q;
    assign write_strobe_n = wr_n_q;
    assign read_strobe_n = rd_n_q;
    assign head_or_replay_input_n = hr_n_q;
    assign chain_token_in_oe_n = tok_oe_n_q;
    assign write_data = wdat_q;

    // Driven value is a constant low, held in a flop for a clean pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chain_token_in_n <= 1'b0;
        end else begin
            chain_token_in_n <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer; a full buffer stalls device reads

    afc_buf #(
        .WIDTH(WORD_W),
        .DEPTH(BUF_DEPTH)
    ) u_rx_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(read_data),
        .out_valid(buf_out_valid),
        .out_ready(rd_rx),
        .out_data(buf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_WR_NOT_FULL: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(write_strobe_n) |-> $past(full_indicator_n))
        else $error("write strobe started while device full");

    AST_RD_NOT_EMPTY: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(read_strobe_n) |-> $past(empty_indicator_n) && $past(auto_q))
        else $error("read strobe started while device empty");

    AST_WR_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(write_strobe_n) |-> !write_strobe_n[*3] ##1 write_strobe_n)
        else $error("write pulse is not three cycles");

    AST_RD_SETTLE: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(read_strobe_n) |->
            (read_strobe_n && write_strobe_n)[*4])
        else $error("new strobe before flags settled after read");

    AST_RST_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(reset_n) |->
            (!reset_n && write_strobe_n && read_strobe_n)[*3] ##1 reset_n)
        else $error("device reset pulse wrong or strobes active");

    AST_TOKEN_ALONE: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(chain_q) |-> !chain_token_in_oe_n && !chain_token_in_n)
        else $error("token input not held low for a lone device");

    AST_MEMBER_SELECT: assert property (@(posedge clk) disable iff (!rst_b)
        $past(chain_q) && !$past(head_q) |-> head_or_replay_input_n)
        else $error("non-head chain member select not high");

    AST_HEAD_SELECT: assert property (@(posedge clk) disable iff (!rst_b)
        $past(chain_q) && $past(head_q) |-> !head_or_replay_input_n)
        else $error("chain head select not low");

    AST_NO_REPLAY: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(state_q == AFC_RT_LO) |-> !$past(chain_q))
        else $error("replay issued in chain mode");

    AST_PUSH_TIME: assert property (@(posedge clk) disable iff (!rst_b)
        buf_in_valid |-> !read_strobe_n && $past(read_strobe_n, 3)
            && buf_in_ready ##1 read_strobe_n)
        else $error("read word captured at the wrong moment");

endmodule : afc_ctrl

`default_nettype wire

//--- afc_dev_model.sv
/*
 * Behavioural model of the strobe-timed nine-bit FIFO device.
 * Assumes its pins come from the controller; flags move FLAG_NS after
 * the strobe edge that causes them.
 */
`timescale 1ns/100ps
`default_nettype none

module afc_dev_model #(
    parameter int DEPTH = 512,
    parameter int FLAG_NS = 20
) (
    input wire logic reset_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic head_or_replay_input_n,
    input wire logic chain_token_in_n,
    input wire logic [8:0] write_data,
    output logic [8:0] read_data,
    output logic empty_indicator_n,
    output logic full_indicator_n,
    output logic half_level_indicator_n
);
    logic [8:0] mem [DEPTH];
    logic [8:0] q;
    logic rd_on;
    logic wr_on;
    int wp;
    int rp;
    int cnt;

    // A released bus shows the inverse of the last word, never a stale copy
    assign read_data = rd_on ? q : ~q;

    initial begin
        {wp, rp, cnt} = '0;
        {rd_on, wr_on, q} = '0;
        {empty_indicator_n, full_indicator_n, half_level_indicator_n} = 3'h3;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(negedge reset_n) begin
        rp = 0;
        cnt = 0;
        // A chained member that is not the head keeps its write pointer
        if (!(head_or_replay_input_n && chain_token_in_n)) wp = 0;
        empty_indicator_n <= #FLAG_NS 1'b0;
        full_indicator_n <= #FLAG_NS 1'b1;
        half_level_indicator_n <= #FLAG_NS 1'b1;
    end

    always @(negedge write_strobe_n) begin
        if (reset_n && full_indicator_n) begin
            wr_on = 1'b1;
            cnt++;
            if (cnt == DEPTH) full_indicator_n <= #FLAG_NS 1'b0;
            if (cnt > DEPTH / 2) half_level_indicator_n <= #FLAG_NS 1'b0;
        end
    end

    always @(posedge write_strobe_n) begin
        if (wr_on) begin
            wr_on = 1'b0;
            mem[wp] = write_data;
            wp = (wp + 1) % DEPTH;
            empty_indicator_n <= #FLAG_NS 1'b1;
        end
    end

    always @(negedge read_strobe_n) begin
        if (reset_n && empty_indicator_n) begin
            rd_on = 1'b1;
            q = mem[rp];
            if (cnt == 1) empty_indicator_n <= #FLAG_NS 1'b0;
        end
    end

    always @(posedge read_strobe_n) begin
        if (rd_on) begin
            rd_on = 1'b0;
            rp = (rp + 1) % DEPTH;
            cnt--;
            full_indicator_n <= #FLAG_NS 1'b1;
            if (cnt <= DEPTH / 2) half_level_indicator_n <= #FLAG_NS 1'b1;
        end
    end

    // Replay only exists while the token input is grounded
    always @(negedge head_or_replay_input_n) begin
        if (reset_n && !chain_token_in_n) begin
            rp = 0;
            cnt = wp;
            empty_indicator_n <= #FLAG_NS (wp != 0);
            half_level_indicator_n <= #FLAG_NS !(wp > DEPTH / 2);
        end
    end
endmodule : afc_dev_model

`default_nettype wire

//--- tb.sv
/*
 * Self-checking bench of the FIFO pin controller with a device model.
 * Assumes the register map of afc_defines.svh and a 16-word model.
 */
`timescale 1ns/100ps
`default_nettype none

`include "afc_defines.svh"

module tb;
    localparam int DEPTH = 16;
    logic clk, rst_b, reg_wr, reg_rd, dev_rst_n, wr_n, rd_n, hr_n;
    logic tok_n, tok_oe_n, empty_n, full_n, half_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [8:0] wdat, rdat;
    // Released token input is pulled to the previous member's idle level
    wire logic tok_line = tok_oe_n ? 1'b1 : tok_n;
    int n_errors = 0;
    int samples_checked = 0;

    afc_ctrl u_afc_ctrl (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reset_n(dev_rst_n), .write_strobe_n(wr_n),
        .read_strobe_n(rd_n), .head_or_replay_input_n(hr_n),
        .chain_token_in_n(tok_n), .chain_token_in_oe_n(tok_oe_n),
        .write_data(wdat), .read_data(rdat), .empty_indicator_n(empty_n),
        .full_indicator_n(full_n), .half_level_indicator_n(half_n));

    // One device: its own flags are the combined ones, never wired together
    afc_dev_model #(.DEPTH(DEPTH)) u_afc_dev_model (
        .reset_n(dev_rst_n),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n),
        .head_or_replay_input_n(hr_n), .chain_token_in_n(tok_line),
        .write_data(wdat), .read_data(rdat), .empty_indicator_n(empty_n),
        .full_indicator_n(full_n), .half_level_indicator_n(half_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    // Busy alone may drop for one cycle between operations
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 400 && quiet < 3; i++) begin
            rd(`AFC_REG_STATUS, rv);
            quiet = (rv[`AFC_ST_BUSY] === 1'b0 && rv[`AFC_ST_TXPEND] === 1'b0)
                ? quiet + 1 : 0;
        end
        if (quiet < 3) begin
            n_errors++;
            results();
        end
    endtask : wait_idle

    task automatic take(input logic [8:0] w);
        rv = '0;
        for (int i = 0; i < 100 && rv[`AFC_RX_VALID] !== 1'b1; i++) begin
            rd(`AFC_REG_RXDATA, rv);
        end
        chk("rxdata", rv, {15'h0000, 1'b1, 7'h00, w});
        if (rv[`AFC_RX_VALID] !== 1'b1) results();
    endtask : take

    ////////////////////////////////////////////////////////////////////////
    task automatic s_reset();
        chk("idle pins", {dev_rst_n, wr_n, rd_n, hr_n}, 4'hF);
        chk("token", {tok_n, tok_oe_n}, 2'b00);
        rd(8'h10, rv);
        chk("unmapped", rv, 32'h0000_0000);
        wr(`AFC_REG_CTRL, 32'h0000_0010);
        wait_idle();
        chk("reset flags", rv[2:0], 3'h6);
    endtask : s_reset

    task automatic s_fill();
        for (int i = 0; i < DEPTH; i++) begin
            wr(`AFC_REG_TXDATA, 32'(9'(i * 37 + 3)));
            wait_idle();
            chk("half_n", rv[2], 32'((i + 1) <= DEPTH / 2));
            chk("full_n", rv[1], 32'((i + 1) != DEPTH));
        end
        wr(`AFC_REG_TXDATA, 32'h0000_00FF);
        repeat (20) @(posedge clk);
        rd(`AFC_REG_STATUS, rv);
        chk("held write", rv[6], 32'h1);
        wr(`AFC_REG_TXDATA, 32'h0000_01EE);
        rd(`AFC_REG_STATUS, rv);
        chk("drop set", rv[5], 32'h1);
        wr(`AFC_REG_STATUS, 32'h0000_0020);
        rd(`AFC_REG_STATUS, rv);
        chk("drop clear", rv[5], 32'h0);
        wr(`AFC_REG_CTRL, 32'h0000_0004);
        for (int i = 0; i < DEPTH; i++) take(9'(i * 37 + 3));
        take(9'h0FF);
        wait_idle();
        chk("drained flags", rv[2:0], 3'h6);
        wr(`AFC_REG_CTRL, 32'h0000_0010);
        wait_idle();
    endtask : s_fill

    task automatic s_replay();
        logic [8:0] w [3] = '{9'h1A5, 9'h05A, 9'h100};
        for (int i = 0; i < 3; i++) begin
            wr(`AFC_REG_TXDATA, {23'h0, w[i]});
            wait_idle();
        end
        chk("empty_n", rv[0], 32'h1);
        wr(`AFC_REG_CTRL, 32'h0000_0004);
        for (int i = 0; i < 3; i++) take(w[i]);
        wait_idle();
        chk("empty_n", rv[0], 32'h0);
        wr(`AFC_REG_CTRL, 32'h0000_0020);
        wait_idle();
        chk("replay empty_n", rv[0], 32'h1);
        wr(`AFC_REG_CTRL, 32'h0000_0004);
        for (int i = 0; i < 3; i++) take(w[i]);
        wr(`AFC_REG_CTRL, 32'h0000_0000);
        wait_idle();
    endtask : s_replay

    task automatic s_chain();
        wr(`AFC_REG_CTRL, 32'h0000_0003);
        repeat (3) @(posedge clk);
        chk("head pins", {hr_n, tok_oe_n}, 2'b01);
        wr(`AFC_REG_CTRL, 32'h0000_0021);
        repeat (3) @(posedge clk);
        repeat (10) begin
            @(negedge clk);
            chk("member select", hr_n, 32'h1);
        end
    endtask : s_chain

    ////////////////////////////////////////////////////////////////////////
    always @(negedge wr_n) begin
        if (rst_b) chk("write gate", full_n, 32'h1);
    end

    always @(negedge rd_n) begin
        if (rst_b) chk("read gate", empty_n, 32'h1);
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        s_reset();
        s_fill();
        s_replay();
        s_chain();
        results();
    end
endmodule : tb

`default_nettype wire
